/* hdl/timer_prescaler_select_map.svh */
`ifndef TIMER_PRESCALER_SELECT_MAP_SVH
`define TIMER_PRESCALER_SELECT_MAP_SVH

// Register indices; byte address is four times the index
`define TPS_IDX_CTRL01     16'hFF20
`define TPS_IDX_CTRL23     16'hFF21
`define TPS_IDX_SRCSEL     16'hFF23

`define TPS_RST_CTRL       8'h00
`define TPS_RST_SRCSEL     5'h00

// Field positions inside a control byte
`define TPS_ODD_GATE_BIT   7
`define TPS_ODD_RATIO_LSB  4
`define TPS_EVEN_GATE_BIT  3
`define TPS_EVEN_RATIO_LSB 0
`define TPS_SRCSEL_W       5

// Divider taps, as log2 of the division
`define TPS_FAST_DIV_W     12
`define TPS_SLOW_DIV_W     7

`endif

/* hdl/timer_prescaler_select_pkg.sv */
`default_nettype none
`include "timer_prescaler_select_map.svh"

package timer_prescaler_select_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic       gate;
    logic       slow_sel;
    logic [2:0] ratio;
  } timer_cfg_t;

endpackage
`default_nettype wire

/* hdl/timer_prescaler_select.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer_prescaler_select_map.svh"

module timer_prescaler_select
  import timer_prescaler_select_pkg::*;
#(
  parameter int FAST_DIV_W = `TPS_FAST_DIV_W,
  parameter int SLOW_DIV_W = `TPS_SLOW_DIV_W
) (
  // Clock and reset
  input  wire logic     i_ref_clk,
  input  wire logic     i_nrst,
  // Register bus
  input  wire apb_req_t i_apb,
  output var  apb_rsp_t o_apb,
  // Oscillator levels
  input  wire logic     i_fast_oscillator,
  input  wire logic     i_slow_oscillator,
  // Divided clock ticks to timers 0-3
  output logic [3:0]    o_timer_tick
);

  localparam int NT = 4;

  // Tap of the chain as a shift count
  function automatic logic [3:0] ratio_shift(input logic [2:0] code, input logic slow);
    logic [3:0] sh;
    sh = 4'h0;
    if (slow) begin
      sh = {1'b0, code};
    end else begin
      unique case (code)
        3'h7: sh = 4'hC;
        3'h6: sh = 4'hA;
        3'h5: sh = 4'h8;
        3'h4: sh = 4'h6;
        3'h3: sh = 4'h5;
        3'h2: sh = 4'h3;
        3'h1: sh = 4'h1;
        3'h0: sh = 4'h0;
      endcase
    end
    return sh;
  endfunction

  // Low bits of the chain all ones
  function automatic logic tap_hit(input logic [15:0] cnt, input logic [3:0] sh);
    logic [15:0] mask;
    mask = ~(16'hFFFF << sh);
    return &(cnt | ~mask);
  endfunction

  // Read value of one register index
  function automatic logic [7:0] read_reg(input logic [15:0] idx, input logic [7:0] c01,
                                          input logic [7:0] c23,
                                          input logic [`TPS_SRCSEL_W-1:0] src);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      `TPS_IDX_CTRL01: v = c01;
      `TPS_IDX_CTRL23: v = c23;
      `TPS_IDX_SRCSEL: v = {3'h0, src};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // Bus slave and control registers
  logic [7:0]               ctrl01;
  logic [7:0]               ctrl23;
  logic [`TPS_SRCSEL_W-1:0] srcsel;
  logic [7:0]               next_ctrl01;
  logic [7:0]               next_ctrl23;
  logic [`TPS_SRCSEL_W-1:0] next_srcsel;
  apb_rsp_t                 next_apb;
  logic [15:0]              bus_idx;
  logic                     bus_mapped;
  logic                     setup;
  logic                     wr_take;

  assign bus_idx    = i_apb.paddr[17:2];
  assign bus_mapped = (i_apb.paddr[1:0] == 2'h0) &&
                      ((bus_idx == `TPS_IDX_CTRL01) || (bus_idx == `TPS_IDX_CTRL23) ||
                       (bus_idx == `TPS_IDX_SRCSEL));
  assign setup      = i_apb.psel && !i_apb.penable;
  assign wr_take    = i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite &&
                      !o_apb.pslverr;

  always_comb begin
    next_ctrl01        = ctrl01;
    next_ctrl23        = ctrl23;
    next_srcsel        = srcsel;
    next_apb.pready    = setup;
    next_apb.pslverr   = setup && !bus_mapped;
    next_apb.prdata    = 32'h0000_0000;
    if (setup && !i_apb.pwrite && bus_mapped) begin
      next_apb.prdata = {24'h00_0000, read_reg(bus_idx, ctrl01, ctrl23, srcsel)};
    end
    if (wr_take) begin
      unique case (bus_idx)
        `TPS_IDX_CTRL01: next_ctrl01 = i_apb.pwdata[7:0];
        `TPS_IDX_CTRL23: next_ctrl23 = i_apb.pwdata[7:0];
        `TPS_IDX_SRCSEL: next_srcsel = i_apb.pwdata[`TPS_SRCSEL_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl01 <= `TPS_RST_CTRL;
      ctrl23 <= `TPS_RST_CTRL;
      srcsel <= `TPS_RST_SRCSEL;
      o_apb  <= '0;
    end else begin
      ctrl01 <= next_ctrl01;
      ctrl23 <= next_ctrl23;
      srcsel <= next_srcsel;
      o_apb  <= next_apb;
    end
  end

  // Per-timer view of the control bytes
  timer_cfg_t cfg [NT];

  always_comb begin
    cfg[0] = {ctrl01[`TPS_EVEN_GATE_BIT], srcsel[0],
              ctrl01[`TPS_EVEN_RATIO_LSB +: 3]};
    cfg[1] = {ctrl01[`TPS_ODD_GATE_BIT], srcsel[1],
              ctrl01[`TPS_ODD_RATIO_LSB +: 3]};
    cfg[2] = {ctrl23[`TPS_EVEN_GATE_BIT], srcsel[2],
              ctrl23[`TPS_EVEN_RATIO_LSB +: 3]};
    cfg[3] = {ctrl23[`TPS_ODD_GATE_BIT], srcsel[3],
              ctrl23[`TPS_ODD_RATIO_LSB +: 3]};
  end

  // Divider chains on each oscillator
  logic                  fast_q;
  logic                  slow_q;
  logic                  fast_edge;
  logic                  slow_edge;
  logic [FAST_DIV_W-1:0] fast_cnt;
  logic [SLOW_DIV_W-1:0] slow_cnt;
  logic [FAST_DIV_W-1:0] next_fast_cnt;
  logic [SLOW_DIV_W-1:0] next_slow_cnt;
  logic [NT-1:0]         next_tick;

  assign fast_edge = i_fast_oscillator && !fast_q;
  assign slow_edge = i_slow_oscillator && !slow_q;

  always_comb begin
    next_fast_cnt = fast_edge ? fast_cnt + 1'b1 : fast_cnt;
    next_slow_cnt = slow_edge ? slow_cnt + 1'b1 : slow_cnt;
    for (int t = 0; t < NT; t++) begin
      if (cfg[t].slow_sel) begin
        next_tick[t] = cfg[t].gate && slow_edge &&
                       tap_hit(16'(slow_cnt), ratio_shift(cfg[t].ratio, 1'b1));
      end else begin
        next_tick[t] = cfg[t].gate && fast_edge &&
                       tap_hit(16'(fast_cnt), ratio_shift(cfg[t].ratio, 1'b0));
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fast_q       <= 1'b0;
      slow_q       <= 1'b0;
      fast_cnt     <= '0;
      slow_cnt     <= '0;
      o_timer_tick <= 4'h0;
    end else begin
      fast_q       <= i_fast_oscillator;
      slow_q       <= i_slow_oscillator;
      fast_cnt     <= next_fast_cnt;
      slow_cnt     <= next_slow_cnt;
      o_timer_tick <= next_tick;
    end
  end

  // Checks
  // Timer 0 watched on the fast chain, timer 2 on the slow chain
  logic       fast0;
  logic       slow2;
  logic [3:0] gates;
  assign fast0 = cfg[0].gate && !cfg[0].slow_sel;
  assign slow2 = cfg[2].gate && cfg[2].slow_sel;
  assign gates = {cfg[3].gate, cfg[2].gate, cfg[1].gate, cfg[0].gate};

  a_ctrl_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (wr_take && bus_idx == `TPS_IDX_CTRL01) |=>
      (cfg[1].gate == $past(i_apb.pwdata[7]) && cfg[0].ratio == $past(i_apb.pwdata[2:0])))
    else $error("control byte write not applied");

  a_gate_stops: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_timer_tick[1] |-> $past(cfg[1].gate))
    else $error("tick while timer clock stopped");

  a_fast_4096: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h7 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[11:0]) == 12'hFFF)))
    else $error("fast divide by 4096 wrong");

  a_fast_64: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h4 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[5:0]) == 6'h3F)))
    else $error("fast divide by 64 wrong");

  a_fast_pass: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h0) |-> ##1 (o_timer_tick[0] == $past(fast_edge)))
    else $error("fast undivided clock wrong");

  a_slow_128: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h7 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[6:0]) == 7'h7F)))
    else $error("slow divide by 128 wrong");

  a_slow_pass: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h0) |=> (o_timer_tick[2] == $past(slow_edge)))
    else $error("slow undivided clock wrong");

  a_src_read: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (setup && !i_apb.pwrite && bus_idx == `TPS_IDX_SRCSEL && bus_mapped) |=>
      (o_apb.pready && o_apb.prdata == {27'h0, $past(srcsel)}))
    else $error("source select readback wrong");

  a_ctrl23_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (wr_take && bus_idx == `TPS_IDX_CTRL23) |=>
      (cfg[3].gate == $past(i_apb.pwdata[7]) && cfg[3].ratio == $past(i_apb.pwdata[6:4]) &&
       cfg[2].gate == $past(i_apb.pwdata[3]) && cfg[2].ratio == $past(i_apb.pwdata[2:0])))
    else $error("second control byte write not applied");

  a_gates_all: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (o_timer_tick & ~$past(gates)) == 4'h0)
    else $error("tick on a stopped timer");

  a_fast_1024: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h6 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[9:0]) == 10'h3FF)))
    else $error("fast divide by 1024 wrong");

  a_fast_256: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h5 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[7:0]) == 8'hFF)))
    else $error("fast divide by 256 wrong");

  a_fast_32: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h3 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[4:0]) == 5'h1F)))
    else $error("fast divide by 32 wrong");

  a_fast_8: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h2 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[2:0]) == 3'h7)))
    else $error("fast divide by 8 wrong");

  a_fast_2: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (fast0 && cfg[0].ratio == 3'h1 && fast_edge) |=>
      (o_timer_tick[0] == ($past(fast_cnt[0]) == 1'h1)))
    else $error("fast divide by 2 wrong");

  a_no_edge_tick: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (!fast_edge && !slow_edge) |=> (o_timer_tick == 4'h0))
    else $error("tick without an oscillator edge");

  a_slow_64: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h6 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[5:0]) == 6'h3F)))
    else $error("slow divide by 64 wrong");

  a_slow_32: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h5 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[4:0]) == 5'h1F)))
    else $error("slow divide by 32 wrong");

  a_slow_16: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h4 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[3:0]) == 4'hF)))
    else $error("slow divide by 16 wrong");

  a_slow_8: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h3 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[2:0]) == 3'h7)))
    else $error("slow divide by 8 wrong");

  a_slow_4: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h2 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[1:0]) == 2'h3)))
    else $error("slow divide by 4 wrong");

  a_slow_2: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (slow2 && cfg[2].ratio == 3'h1 && slow_edge) |=>
      (o_timer_tick[2] == ($past(slow_cnt[0]) == 1'h1)))
    else $error("slow divide by 2 wrong");

  a_src_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (wr_take && bus_idx == `TPS_IDX_SRCSEL) |=> (srcsel == $past(i_apb.pwdata[4:0])))
    else $error("source select write not applied");

  a_reset_clear: assert property (@(posedge i_ref_clk)
    $rose(i_nrst) |-> (ctrl01 == `TPS_RST_CTRL && ctrl23 == `TPS_RST_CTRL &&
                       srcsel == `TPS_RST_SRCSEL && o_timer_tick == 4'h0))
    else $error("control state not cleared by reset");

endmodule
`default_nettype wire

/* tb/timer_prescaler_select_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "timer_prescaler_select_map.svh"

module timer_prescaler_select_tb;
  import timer_prescaler_select_pkg::*;

  logic        i_ref_clk = 1'h0;
  logic        i_nrst    = 1'h0;
  apb_req_t    req       = '0;
  apb_rsp_t    rsp;
  logic        fast_osc  = 1'h0;
  logic        slow_osc  = 1'h0;
  logic [3:0]  tick;
  logic [1:0]  ph        = 2'h0;
  logic [31:0] rnd       = 32'hD2368E94;
  logic [32:0] q[$];
  logic [3:0]  flog[8]   = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};
  int          bad_count = 0;
  int          compares  = 0;
  int          cyc       = 0;

  timer_prescaler_select i_timer_prescaler_select (
    .i_ref_clk         (i_ref_clk),
    .i_nrst            (i_nrst),
    .i_apb             (req),
    .o_apb             (rsp),
    .i_fast_oscillator (fast_osc),
    .i_slow_oscillator (slow_osc),
    .o_timer_tick      (tick)
  );

  always #2 i_ref_clk = ~i_ref_clk;

  // Both sources period 4; slow rises one cycle before fast
  always @(posedge i_ref_clk) begin
    ph <= ph + 2'h1;
    fast_osc <= ph[1];
    slow_osc <= ph[1] ^ ph[0];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string name, input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One setup cycle, then holds access until pready; caller releases the bus
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     input logic [32:0] exp);
    q.push_back(exp);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {idx, 2'h0}, pwdata: {24'h0, d}};
    @(posedge i_ref_clk);
    req.penable <= 1'h1;
    do @(posedge i_ref_clk); while (rsp.pready !== 1'h1);
  endtask

  always @(posedge i_ref_clk) begin
    if (rsp.pready === 1'h1) begin
      check("apb_resp", {rsp.pslverr, rsp.prdata}, q.size() ? q.pop_front() : 33'h1FFFFFFFF);
    end
  end

  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    logic [3:0]  g;
    logic [4:0]  s;
    logic [32:0] cnt[4];
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'h1;
    @(posedge i_ref_clk);
    apb(1'h0, `TPS_IDX_CTRL01, 8'h00, {25'h0, `TPS_RST_CTRL});
    apb(1'h0, `TPS_IDX_CTRL23, 8'h00, {25'h0, `TPS_RST_CTRL});
    apb(1'h0, `TPS_IDX_SRCSEL, 8'h00, 33'h0);
    apb(1'h1, `TPS_IDX_SRCSEL, 8'hFF, 33'h0);
    apb(1'h0, `TPS_IDX_SRCSEL, 8'h00, 33'h1F);
    apb(1'h1, 16'hFF22, 8'hFF, {1'h1, 32'h0});
    apb(1'h0, 16'hFF22, 8'h00, {1'h1, 32'h0});
    for (int c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      // Timer 0 always fast, timer 2 always slow, both running
      g = rnd[3:0] | 4'h5;
      s = (rnd[8:4] & 5'h1A) | 5'h04;
      apb(1'h1, `TPS_IDX_CTRL01, {g[1], c[2:0], g[0], c[2:0]}, 33'h0);
      apb(1'h1, `TPS_IDX_CTRL23, {g[3], c[2:0], g[2], c[2:0]}, 33'h0);
      apb(1'h1, `TPS_IDX_SRCSEL, {3'h0, s}, 33'h0);
      apb(1'h0, `TPS_IDX_CTRL23, 8'h00, {25'h0, g[3], c[2:0], g[2], c[2:0]});
      req <= '0;
      do @(posedge i_ref_clk); while (ph !== 2'h2);
      cnt = '{default: 33'h0};
      // Window spans a whole number of periods of every tap
      repeat (4 << flog[c]) begin
        @(posedge i_ref_clk);
        for (int t = 0; t < 4; t++) cnt[t] = cnt[t] + {32'h0, tick[t]};
      end
      for (int t = 0; t < 4; t++) begin
        check("tick_count", cnt[t], g[t] ? (33'h1 << flog[c]) >> (s[t] ? c : flog[c]) : 33'h0);
      end
    end
    // Mid-run reset clears every control byte
    i_nrst <= 1'h0;
    @(posedge i_ref_clk);
    i_nrst <= 1'h1;
    @(posedge i_ref_clk);
    apb(1'h0, `TPS_IDX_CTRL01, 8'h00, {25'h0, `TPS_RST_CTRL});
    apb(1'h0, `TPS_IDX_CTRL23, 8'h00, {25'h0, `TPS_RST_CTRL});
    apb(1'h0, `TPS_IDX_SRCSEL, 8'h00, {28'h0, `TPS_RST_SRCSEL});
    req <= '0;
    @(posedge i_ref_clk);
    end_sim();
  end

endmodule
`default_nettype wire
